// [inc/ep_status_defines.vh]
/*
 * Register offsets, field positions and reset values for the device status
 * and endpoint common interrupt enable block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef EP_STATUS_DEFINES_VH
`define EP_STATUS_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_DEVICE_MODE_STATUS  12'h808
`define OFS_IN_EP_COMMON_EN     12'h810
`define OFS_OUT_EP_COMMON_EN    12'h814
`define OFS_ALL_EP_IRQ_BITS     12'h818
`define OFS_EVENT_STATUS        12'h840
`define OFS_EVENT_MASK          12'h844

// ----------------------------------------------------------------------------
// device_mode_status fields
// ----------------------------------------------------------------------------
`define STAT_FRAME_HI           21
`define STAT_FRAME_LO           8
`define STAT_SPEED_HI           2
`define STAT_SPEED_LO           1
`define STAT_SUSPEND_BIT        0
`define SPEED_FULL              2'h3

// ----------------------------------------------------------------------------
// common enable fields (shared layout for IN and OUT)
// ----------------------------------------------------------------------------
`define EN_WRITABLE_MASK        7'h5B
`define EN_RESET                7'h00
`define EN_IN_NAK_EFF_BIT       6
`define EN_OUT_B2B_SETUP_BIT    6
`define EN_FIFO_ERR_BIT         4
`define EN_CTRL_PHASE_BIT       3
`define EN_EP_DISABLED_BIT      1
`define EN_XFER_DONE_BIT        0

// ----------------------------------------------------------------------------
// all-endpoint bits and event status layout
// ----------------------------------------------------------------------------
`define ALL_EP_OUT_LO           16
`define EVT_SOF_BIT             0
`define EVT_SUSPEND_BIT         1
`define EVT_ENUM_BIT            2
`define EVT_EP_BIT              3
`define EVT_RESET               4'h0

`endif

// [hw/ep_irq_reduce.v]
/*
 * Per-endpoint reduction of flag vectors through a common enable mask.
 * Assumes flags are level inputs on the same clock as the enable.
 */
`timescale 1ns/1ps
module ep_irq_reduce #(
    parameter NUM_EP    = 4,
    parameter FLAG_W    = 7
) (
    input  wire [NUM_EP*FLAG_W-1:0] flags_in,      // packed flag vectors, ep0 lowest
    input  wire [FLAG_W-1:0]        enable_in,     // common enable mask
    output wire [NUM_EP-1:0]        ep_bits_out    // one bit per endpoint
);

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1)
        begin : g_ep
            assign ep_bits_out[g] = |(flags_in[g*FLAG_W +: FLAG_W] & enable_in); // R5 R17
        end
    endgenerate

endmodule // ep_irq_reduce

// [hw/evt_sticky.v]
/*
 * Sticky event status with read-to-clear and mask-gated level interrupt.
 * Assumes events are one-cycle pulses on clk_in.
 */
`timescale 1ns/1ps
`include "ep_status_defines.vh"
module evt_sticky #(
    parameter W = 4
) (
    input  wire         clk_in,       // core clock
    input  wire         srst_in,      // sync reset, active high
    input  wire [W-1:0] event_in,     // event pulses
    input  wire         clear_in,     // status read, clears all bits
    input  wire [W-1:0] mask_in,      // 1 lets a bit reach the interrupt
    output reg  [W-1:0] status_out,   // sticky bits
    output reg          irq_out       // level interrupt
);

    wire [W-1:0] status_d;

    // a new event in the clearing cycle survives the clear
    assign status_d = (clear_in ? {W{1'b0}} : status_out) | event_in;

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            status_out <= `EVT_RESET;
            irq_out    <= 1'b0;
        end
        else
        begin
            status_out <= status_d;
            irq_out    <= |(status_d & mask_in);
        end
    end

endmodule // evt_sticky

// [hw/dev_status_ep_irq.v]
/*
 * Device-mode status register and common IN/OUT endpoint interrupt enables,
 * with the all-endpoint interrupt bits and a small event interrupt.
 * Assumes the core's token decoder, suspend detector and endpoint flag
 * registers sit on clk_in; the USB-side status inputs come straight from
 * that logic and need no synchroniser.
 */
`timescale 1ns/1ps
`include "ep_status_defines.vh"

// Function
// R1 - frame number from each SOF, bits 21:8
// R2 - speed field bits 2:1, 11 full
// R3 - software reads speed after enumeration done
// R4 - bit 0 low while suspended
// R5 - flag counts only with its enable set
// R6 - enables change only by software writes
// R7 - IN bit 6 gates NAK effective
// R8 - IN bit 4 gates Tx underrun
// R9 - IN bit 3 gates control IN timeout
// R10 - bit 1 gates endpoint disabled
// R11 - bit 0 gates transfer finished
// R12 - OUT bit 6 gates back-to-back setup
// R13 - OUT bit 4 gates Rx overrun
// R14 - OUT bit 3 gates setup phase done
// R15 - software keeps reserved bits at reset
// R16 - OUT eps bits 16-19, IN 0-3
// R17 - ep bit is OR of enabled flags
module dev_status_ep_irq #(
    parameter NUM_EP    = 4,
    parameter FLAG_W    = 7,
    parameter ADDR_W    = 12
) (
    input  wire                     clk_in,            // usb core clock
    input  wire                     srst_in,           // sync reset, active high
    input  wire [ADDR_W-1:0]        addr_in,           // register byte address
    input  wire [31:0]              wdata_in,          // write data
    input  wire                     wr_in,             // write strobe
    input  wire                     rd_in,             // read strobe
    output reg  [31:0]              rdata_out,         // read data, cycle after rd_in
    input  wire                     sof_valid_in,      // pulse: SOF token received
    input  wire [13:0]              sof_frame_in,      // frame number of that SOF
    input  wire                     suspended_in,      // level: bus in suspend
    input  wire                     enum_done_in,      // pulse: enumeration finished
    input  wire [1:0]               speed_in,          // negotiated speed code
    input  wire [NUM_EP*FLAG_W-1:0] in_ep_flags_in,    // IN ep flag vectors
    input  wire [NUM_EP*FLAG_W-1:0] out_ep_flags_in,   // OUT ep flag vectors
    output reg  [NUM_EP-1:0]        in_ep_irq_out,     // IN endpoint interrupt bits
    output reg  [NUM_EP-1:0]        out_ep_irq_out,    // OUT endpoint interrupt bits
    output wire                     irq_out            // level interrupt
);

    // ------------------------------------------------------------------------
    // status state
    // ------------------------------------------------------------------------
    reg  [13:0]       frame_q;
    reg  [1:0]        speed_q;
    reg               not_suspended_q;
    reg  [FLAG_W-1:0] in_en_q;
    reg  [FLAG_W-1:0] out_en_q;
    reg  [3:0]        evt_mask_q;
    reg               suspended_prev_q;
    reg               ep_any_prev_q;

    wire [NUM_EP-1:0] in_bits;
    wire [NUM_EP-1:0] out_bits;
    wire [3:0]        evt_status;
    wire              irq_w;
    wire [3:0]        events;
    wire              ep_any;
    wire              evt_clear;

    function sel;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] ofs;
        begin
            sel = (a == ofs);
        end
    endfunction

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            frame_q          <= 14'h0000;
            speed_q          <= 2'h0;
            not_suspended_q  <= 1'b0;
            suspended_prev_q <= 1'b0;
        end
        else
        begin
            if (sof_valid_in)
                frame_q <= sof_frame_in;                  // R1
            if (enum_done_in)
                speed_q <= speed_in;                      // R2
            not_suspended_q  <= ~suspended_in;            // R4
            suspended_prev_q <= suspended_in;
        end
    end

    // ------------------------------------------------------------------------
    // enable and mask registers
    // ------------------------------------------------------------------------
    // only the write strobe reaches these; no hardware path touches them
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            in_en_q    <= `EN_RESET;
            out_en_q   <= `EN_RESET;
            evt_mask_q <= `EVT_RESET;
        end
        else if (wr_in)
        begin
            if (sel(addr_in, `OFS_IN_EP_COMMON_EN))
                in_en_q <= wdata_in[FLAG_W-1:0] & `EN_WRITABLE_MASK;   // R6 R7 R8 R9 R10 R11
            if (sel(addr_in, `OFS_OUT_EP_COMMON_EN))
                out_en_q <= wdata_in[FLAG_W-1:0] & `EN_WRITABLE_MASK;  // R6 R12 R13 R14 R10 R11
            if (sel(addr_in, `OFS_EVENT_MASK))
                evt_mask_q <= wdata_in[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // endpoint interrupt bits
    // ------------------------------------------------------------------------
    ep_irq_reduce #(
        .NUM_EP      (NUM_EP),
        .FLAG_W      (FLAG_W)
    ) u_in_reduce (
        .flags_in    (in_ep_flags_in),
        .enable_in   (in_en_q),
        .ep_bits_out (in_bits)
    );

    ep_irq_reduce #(
        .NUM_EP      (NUM_EP),
        .FLAG_W      (FLAG_W)
    ) u_out_reduce (
        .flags_in    (out_ep_flags_in),
        .enable_in   (out_en_q),
        .ep_bits_out (out_bits)
    );

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            in_ep_irq_out  <= {NUM_EP{1'b0}};
            out_ep_irq_out <= {NUM_EP{1'b0}};
            ep_any_prev_q  <= 1'b0;
        end
        else
        begin
            in_ep_irq_out  <= in_bits;    // R17
            out_ep_irq_out <= out_bits;   // R17
            ep_any_prev_q  <= ep_any;
        end
    end

    // ------------------------------------------------------------------------
    // events
    // ------------------------------------------------------------------------
    assign ep_any    = |in_bits | |out_bits;
    assign evt_clear = rd_in & sel(addr_in, `OFS_EVENT_STATUS);
    assign events    = {ep_any & ~ep_any_prev_q,
                        enum_done_in,
                        suspended_in & ~suspended_prev_q,
                        sof_valid_in};

    evt_sticky #(
        .W          (4)
    ) u_evt (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .event_in   (events),
        .clear_in   (evt_clear),
        .mask_in    (evt_mask_q),
        .status_out (evt_status),
        .irq_out    (irq_w)
    );

    assign irq_out = irq_w;

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    reg [31:0] rdata_d;

    always @*
    begin
        rdata_d = 32'h0000_0000;
        if (sel(addr_in, `OFS_DEVICE_MODE_STATUS))
        begin
            rdata_d[`STAT_FRAME_HI:`STAT_FRAME_LO] = frame_q;           // R1
            rdata_d[`STAT_SPEED_HI:`STAT_SPEED_LO] = speed_q;           // R2
            rdata_d[`STAT_SUSPEND_BIT]             = not_suspended_q;   // R4
        end
        else if (sel(addr_in, `OFS_IN_EP_COMMON_EN))
            rdata_d[FLAG_W-1:0] = in_en_q;
        else if (sel(addr_in, `OFS_OUT_EP_COMMON_EN))
            rdata_d[FLAG_W-1:0] = out_en_q;
        else if (sel(addr_in, `OFS_ALL_EP_IRQ_BITS))
        begin
            rdata_d[NUM_EP-1:0]                      = in_ep_irq_out;   // R16
            rdata_d[`ALL_EP_OUT_LO +: NUM_EP]        = out_ep_irq_out;  // R16
        end
        else if (sel(addr_in, `OFS_EVENT_STATUS))
            rdata_d[3:0] = evt_status;
        else if (sel(addr_in, `OFS_EVENT_MASK))
            rdata_d[3:0] = evt_mask_q;
    end

    // unmapped addresses and idle cycles read as zero
    always @(posedge clk_in)
    begin
        if (srst_in)
            rdata_out <= 32'h0000_0000;
        else if (rd_in)
            rdata_out <= rdata_d;
        else
            rdata_out <= 32'h0000_0000;
    end

endmodule // dev_status_ep_irq

// [verification/dev_status_ep_irq_checker.sv]
/* Port assertions for dev_status_ep_irq.
   Assumes it is bound to each instance; it tracks enables from bus writes. */
`timescale 1ns/1ps
module dev_status_ep_irq_checker #(
    parameter NUM_EP = 4,
    parameter FLAG_W = 7,
    parameter ADDR_W = 12
) (
    input wire                     clk_in,          // clock
    input wire                     srst_in,         // reset
    input wire [ADDR_W-1:0]        addr_in,         // address
    input wire [31:0]              wdata_in,        // write data
    input wire                     wr_in,           // write
    input wire                     rd_in,           // read
    input wire [31:0]              rdata_out,       // read data
    input wire                     sof_valid_in,    // sof
    input wire [13:0]              sof_frame_in,    // frame
    input wire                     suspended_in,    // suspend
    input wire                     enum_done_in,    // enum done
    input wire [1:0]               speed_in,        // speed
    input wire [NUM_EP*FLAG_W-1:0] in_ep_flags_in,  // in flags
    input wire [NUM_EP*FLAG_W-1:0] out_ep_flags_in, // out flags
    input wire [NUM_EP-1:0]        in_ep_irq_out,   // in bits
    input wire [NUM_EP-1:0]        out_ep_irq_out   // out bits
);
    reg [FLAG_W-1:0] ien_q, oen_q;
    reg [13:0]       frm_q;
    reg [1:0]        spd_q;
    function [NUM_EP-1:0] red(input [NUM_EP*FLAG_W-1:0] f, input [FLAG_W-1:0] e);
        integer n;
        for (n = 0; n < NUM_EP; n = n + 1)
            red[n] = |(f[n*FLAG_W+:FLAG_W] & e);
    endfunction
    wire [NUM_EP-1:0] in_red  = red(in_ep_flags_in, ien_q);
    wire [NUM_EP-1:0] out_red = red(out_ep_flags_in, oen_q);
    wire              rd_stat = rd_in && addr_in == 12'h808;
    // shadow state mirrors only what the bus and status inputs can change
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ien_q <= 7'h00;
            oen_q <= 7'h00;
            frm_q <= 14'h0000;
            spd_q <= 2'h0;
        end
        else
        begin
            if (wr_in && addr_in == 12'h810)
                ien_q <= wdata_in[6:0] & 7'h5B;
            if (wr_in && addr_in == 12'h814)
                oen_q <= wdata_in[6:0] & 7'h5B;
            if (sof_valid_in)
                frm_q <= sof_frame_in;
            if (enum_done_in)
                spd_q <= speed_in;
        end
    end
    // ------------------------------------------
    // assertions
    // ------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    in_gate_a: assert property (in_ep_irq_out == $past(in_red))
        else $error("in endpoint bits wrong");
    out_gate_a: assert property (out_ep_irq_out == $past(out_red))
        else $error("out endpoint bits wrong");
    in_en_read_a: assert property (rd_in && addr_in == 12'h810 |=>
        rdata_out == {25'h0, $past(ien_q)}) else $error("in enable readback wrong");
    out_en_read_a: assert property (rd_in && addr_in == 12'h814 |=>
        rdata_out == {25'h0, $past(oen_q)}) else $error("out enable readback wrong");
    frame_read_a: assert property (rd_stat |=> rdata_out[21:8] == $past(frm_q))
        else $error("frame number wrong");
    speed_read_a: assert property (rd_stat |=> rdata_out[2:1] == $past(spd_q))
        else $error("speed field wrong");
    suspend_read_a: assert property (rd_stat && !$past(srst_in) |=>
        rdata_out[0] == !$past(suspended_in, 2)) else $error("suspend bit wrong");
    all_ep_read_a: assert property (rd_in && addr_in == 12'h818 |=> rdata_out ==
        {12'h0, $past(out_ep_irq_out), 12'h0, $past(in_ep_irq_out)})
        else $error("endpoint bit layout wrong");
endmodule // dev_status_ep_irq_checker

bind dev_status_ep_irq dev_status_ep_irq_checker #(
    .NUM_EP(NUM_EP), .FLAG_W(FLAG_W), .ADDR_W(ADDR_W)) i_checker (.*);

// [verification/usb_host_model.sv]
/* Host-side model: SOF tokens, enumeration and suspend toward the device.
   Assumes one process calls its tasks, all timed on clk_in. */
`timescale 1ns/1ps
module usb_host_model (
    input  wire        clk_in,        // core clock
    output reg         sof_valid_out, // sof pulse
    output reg  [13:0] sof_frame_out, // frame number
    output reg         suspended_out, // suspend level
    output reg         enum_done_out, // enum pulse
    output reg  [1:0]  speed_out      // speed code
);
    initial
    begin
        sof_valid_out = 1'b0;
        sof_frame_out = 14'h0000;
        suspended_out = 1'b0;
        enum_done_out = 1'b0;
        speed_out     = 2'h0;
    end
    // values are inverted after the pulse so a stale field is never taken as live
    task sof(input [13:0] f);
    begin
        @(posedge clk_in);
        sof_frame_out <= f;
        sof_valid_out <= 1'b1;
        @(posedge clk_in);
        sof_valid_out <= 1'b0;
        sof_frame_out <= ~f;
    end
    endtask
    task enumerate(input [1:0] s);
    begin
        @(posedge clk_in);
        speed_out     <= s;
        enum_done_out <= 1'b1;
        @(posedge clk_in);
        enum_done_out <= 1'b0;
        speed_out     <= ~s;
    end
    endtask
    task suspend(input s);
    begin
        @(posedge clk_in);
        suspended_out <= s;
    end
    endtask
endmodule // usb_host_model

// [verification/tb_dev_status_ep_irq.sv]
/* Testbench for dev_status_ep_irq: registers, endpoint gating, status, interrupt.
   Assumes the host model drives the status inputs and the checker is bound. */
`timescale 1ns/1ps
module tb_dev_status_ep_irq;
    reg         clk_in = 1'b0;
    reg         srst_in = 1'b1;
    reg  [11:0] addr_in = 12'h000;
    reg  [31:0] wdata_in = 32'h0;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg  [27:0] in_f = 28'h0;
    reg  [27:0] out_f = 28'h0;
    reg  [31:0] d, r1;
    reg  [6:0]  ien, oen;
    wire [31:0] rdata_out;
    wire [13:0] frame;
    wire [1:0]  speed;
    wire [3:0]  in_irq, out_irq;
    wire        sof_v, susp, enum_d, irq_out;
    integer     n_errors = 0;
    integer     n_tests = 0;
    integer     i;
    initial forever #4 clk_in = ~clk_in;
    usb_host_model host (.clk_in(clk_in), .sof_valid_out(sof_v), .sof_frame_out(frame),
        .suspended_out(susp), .enum_done_out(enum_d), .speed_out(speed));
    dev_status_ep_irq i_dev_status_ep_irq (.clk_in(clk_in), .srst_in(srst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sof_valid_in(sof_v), .sof_frame_in(frame),
        .suspended_in(susp), .enum_done_in(enum_d), .speed_in(speed),
        .in_ep_flags_in(in_f), .out_ep_flags_in(out_f), .in_ep_irq_out(in_irq),
        .out_ep_irq_out(out_irq), .irq_out(irq_out));
    function [31:0] red(input [27:0] f, input [6:0] e);
        integer n;
        begin
            red = 32'h0;
            for (n = 0; n < 4; n = n + 1)
                red[n] = |(f[n*7+:7] & e);
        end
    endfunction
    task chk(input [95:0] what, input [31:0] exp, input [31:0] got);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            $display("wrong value %0s exp %h got %h", what, exp, got);
            n_errors = n_errors + 1;
        end
    end
    endtask
    task wr(input [11:0] a, input [31:0] v);
    begin
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    end
    endtask
    // read data stand one cycle only, so they are taken just after the answering edge
    task rd(input [11:0] a);
    begin
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    end
    endtask
    task wait_cy(input integer n);
    begin
        repeat (n) @(posedge clk_in);
        #1;
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    // ------------------------------------------
    // test sequence
    // ------------------------------------------
    initial
    begin
        void'($urandom(23));
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_cy(2);
        rd(12'h808);
        chk("status", 32'h1, d);
        for (i = 0; i < 3; i = i + 1)
        begin
            rd(12'h810 + {i[9:0], 2'h0});
            chk("reset", 32'h0, d);
        end
        $display("reset values done");
        for (i = 0; i < 40; i = i + 1)
        begin
            r1 = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000024 : $urandom;
            wr(12'h810, r1);
            ien = r1[6:0] & 7'h5B;
            r1 = (i == 0) ? 32'hFFFFFFFF : $urandom;
            wr(12'h814, r1);
            oen = r1[6:0] & 7'h5B;
            r1 = $urandom;
            @(posedge clk_in);
            in_f  <= (i == 1) ? 28'hFFFFFFF : r1[27:0];
            out_f <= ~r1[27:0];
            wait_cy(2);
            chk("in irq", red(in_f, ien), {28'h0, in_irq});
            chk("out irq", red(out_f, oen), {28'h0, out_irq});
            rd(12'h818);
            chk("all ep", {red(out_f, oen), 16'h0} | red(in_f, ien), d);
            rd(12'h810);
            chk("in en", {25'h0, ien}, d);
            rd(12'h814);
            chk("out en", {25'h0, oen}, d);
        end
        wr(12'h900, 32'hFFFFFFFF);
        rd(12'h900);
        chk("unmapped", 32'h0, d);
        rd(12'h810);
        chk("in en", {25'h0, ien}, d);
        $display("enables done");
        for (i = 0; i < 8; i = i + 1)
        begin
            r1 = (i == 0) ? 32'h3FFF : $urandom;
            host.sof(r1[13:0]);
            host.enumerate(i[1:0]);
            host.suspend(i[0]);
            wait_cy(2);
            rd(12'h808);
            chk("status", {10'h0, r1[13:0], 5'h0, i[1:0], ~i[0]}, d);
        end
        $display("status done");
        @(posedge clk_in);
        in_f  <= 28'h0;
        out_f <= 28'h0;
        wr(12'h844, 32'h1);
        rd(12'h844);
        chk("mask", 32'h1, d);
        rd(12'h840);
        wait_cy(1);
        chk("irq idle", 32'h0, {31'h0, irq_out});
        host.sof(14'h0123);
        wait_cy(2);
        chk("irq sof", 32'h1, {31'h0, irq_out});
        rd(12'h840);
        chk("event", 32'h1, d & 32'h1);
        wait_cy(1);
        chk("irq clear", 32'h0, {31'h0, irq_out});
        wr(12'h844, 32'h0);
        host.sof(14'h2AAA);
        wait_cy(2);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        rd(12'h840);
        chk("event", 32'h1, d & 32'h1);
        $display("interrupt done");
        tally_and_finish;
    end
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_errors = n_errors + 1;
        tally_and_finish;
    end
endmodule // tb_dev_status_ep_irq
